/* File: hw/dcr_register_bank.sv */
`timescale 1ns/1ps
module dcr_register_bank (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // register write port from the serial decoder
   input  wire logic                   wrValid,
   input  wire dcr_pkg::dcr_wr_t       wr,
   // register read port
   input  wire logic [4:0]             rdAddr,
   output logic [31:0]                 rdData,
   // device pins
   input  wire logic                   ioUpdatePin,
   input  wire logic                   extPowerDownPin,
   // configuration outputs
   output dcr_pkg::dcr_glob_out_t      globOut,
   output dcr_pkg::dcr_chan_out_t      chanOut [dcr_pkg::NUM_CHAN]
);
   import dcr_pkg::*;

   //------------------------------------------------------------------
   // state
   //------------------------------------------------------------------
   logic [7:0]      chSel_ff;
   logic [23:0]     shGf1_ff;
   logic [23:0]     actGf1_ff;
   logic [15:0]     shGf2_ff;
   logic [15:0]     actGf2_ff;
   dcr_chan_regs_t  sh_ff [NUM_CHAN];
   dcr_chan_regs_t  act_ff [NUM_CHAN];
   logic [15:0]     sweepTmr_ff [NUM_CHAN];
   logic [7:0]      ampTmr_ff [NUM_CHAN];
   logic [2:0]      updSync_ff;
   logic [2:0]      pdSync_ff;
   logic            updLvl_ff;
   logic            pdLvl_ff;
   logic [1:0]      syncDiv_ff;
   logic [31:0]     rdData_ff;
   dcr_glob_out_t   globOut_ff;
   dcr_chan_out_t   chanOut_ff [NUM_CHAN];

   //------------------------------------------------------------------
   // pin synchronisers with agreement filter
   //------------------------------------------------------------------
   wire updAgree = (updSync_ff[1] == updSync_ff[2]);
   wire pdAgree  = (pdSync_ff[1] == pdSync_ff[2]);
   wire updEvt   = updAgree & updSync_ff[2] & ~updLvl_ff;   // filtered rising edge

   // three stages each; a level counts once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         updSync_ff <= 3'h0;
         pdSync_ff  <= 3'h0;
         updLvl_ff  <= 1'b0;
         pdLvl_ff   <= 1'b0;
      end else begin
         updSync_ff <= {updSync_ff[1:0], ioUpdatePin};
         pdSync_ff  <= {pdSync_ff[1:0], extPowerDownPin};
         if (updAgree) updLvl_ff <= updSync_ff[2];
         if (pdAgree) pdLvl_ff <= pdSync_ff[2];
      end
   end

   //------------------------------------------------------------------
   // write decode
   //------------------------------------------------------------------
   wire wrChSel = wrValid && (wr.addr == ADDR_CHSEL);
   wire wrGf1   = wrValid && (wr.addr == ADDR_GF1);
   wire wrGf2   = wrValid && (wr.addr == ADDR_GF2);
   wire wrCf    = wrValid && (wr.addr == ADDR_CF);
   wire wrFtw   = wrValid && (wr.addr == ADDR_FTW);
   wire wrPow   = wrValid && (wr.addr == ADDR_POW);
   wire wrAc    = wrValid && (wr.addr == ADDR_AC);
   wire wrRate  = wrValid && (wr.addr == ADDR_RATE);
   wire wrRise  = wrValid && (wr.addr == ADDR_RISE);
   wire wrFall  = wrValid && (wr.addr == ADDR_FALL);

   // channel enables act at once; global words wait in a shadow copy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chSel_ff  <= CHSEL_RESET;
         shGf1_ff  <= GF1_RESET;
         shGf2_ff  <= GF2_RESET;
         actGf1_ff <= GF1_RESET;
         actGf2_ff <= GF2_RESET;
      end else begin
         if (wrChSel) chSel_ff <= wr.data[7:0];
         if (wrGf1) shGf1_ff <= wr.data[23:0];
         if (wrGf2) shGf2_ff <= wr.data[15:0];
         if (updEvt) begin
            actGf1_ff <= shGf1_ff;
            actGf2_ff <= shGf2_ff;
         end
      end
   end

   //------------------------------------------------------------------
   // per-channel registers, timers and decoded outputs
   //------------------------------------------------------------------
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      wire chEn       = chSel_ff[CHEN_LSB + i];
      wire cfRateLd   = act_ff[i].cf[CF_RATE_LD];
      wire acRateLd   = act_ff[i].ac[AC_RATE_LD];
      wire sweepOn    = act_ff[i].cf[CF_SWEEP];
      wire multOn     = act_ff[i].ac[AC_MULT];
      wire sweepTo    = (sweepTmr_ff[i] <= SWEEP_TIMEOUT);
      wire ampTo      = (ampTmr_ff[i] <= AMP_TIMEOUT);
      wire sweepRld   = sweepTo | (updEvt & cfRateLd);
      wire ampRld     = ampTo | (updEvt & acRateLd);
      wire phZeroReq  = updEvt & (shGf2_ff[GF2_PH_AUTO] | sh_ff[i].cf[CF_PH_AUTO]);
      wire swZeroReq  = updEvt & (shGf2_ff[GF2_SW_AUTO] | sh_ff[i].cf[CF_SW_AUTO]);

      // shadow copy takes writes only when this channel is enabled
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sh_ff[i] <= '0;
         end else if (chEn) begin
            if (wrCf) sh_ff[i].cf <= wr.data[23:0];
            if (wrFtw) sh_ff[i].ftw <= wr.data;
            if (wrPow) sh_ff[i].pow <= wr.data[15:0];
            if (wrAc) sh_ff[i].ac <= wr.data[23:0];
            if (wrRate) sh_ff[i].rate <= wr.data[15:0];
            if (wrRise) sh_ff[i].riseDelta <= wr.data;
            if (wrFall) sh_ff[i].fallDelta <= wr.data;
         end
      end

      // active copy follows the shadow on each update event
      always_ff @(posedge clk or posedge rst) begin
         if (rst) act_ff[i] <= '0;
         else if (updEvt) act_ff[i] <= sh_ff[i];
      end

      // ramp rate timers count down and reload at timeout
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sweepTmr_ff[i] <= '0;
            ampTmr_ff[i]   <= '0;
         end else begin
            sweepTmr_ff[i] <= sweepRld ? act_ff[i].rate : sweepTmr_ff[i] - 16'h0001;
            ampTmr_ff[i]   <= ampRld ? act_ff[i].ac[AC_RATE_LSB +: 8] : ampTmr_ff[i] - 8'h01;
         end
      end

      // registered channel outputs
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            chanOut_ff[i] <= '0;
         end else begin
            chanOut_ff[i].sineSel   <= act_ff[i].cf[CF_SINE];
            chanOut_ff[i].phaseHold <= actGf2_ff[GF2_PH_HOLD] | act_ff[i].cf[CF_PH_HOLD];
            chanOut_ff[i].sweepHold <= actGf2_ff[GF2_SW_HOLD] | act_ff[i].cf[CF_SW_HOLD];
            chanOut_ff[i].phaseZero <= phZeroReq;
            chanOut_ff[i].sweepZero <= swZeroReq;
            chanOut_ff[i].dacPd     <= act_ff[i].cf[CF_DAC_PD];
            chanOut_ff[i].digPd     <= act_ff[i].cf[CF_DIG_PD];
            chanOut_ff[i].sweepEn   <= sweepOn;
            chanOut_ff[i].noDwell   <= sweepOn & act_ff[i].cf[CF_NO_DWELL];
            chanOut_ff[i].sweepStep <= sweepOn & sweepTo;
            chanOut_ff[i].ampStep   <= multOn & act_ff[i].ac[AC_AUTO] & ampTo;
            chanOut_ff[i].multEn    <= multOn;
            chanOut_ff[i].autoRamp  <= multOn & act_ff[i].ac[AC_AUTO];
            chanOut_ff[i].asf       <= act_ff[i].ac[9:0];
            chanOut_ff[i].phaseOfs  <= act_ff[i].pow[13:0];
            chanOut_ff[i].ftw       <= act_ff[i].ftw;
            chanOut_ff[i].rate      <= act_ff[i].rate;
            chanOut_ff[i].riseDelta <= act_ff[i].riseDelta;
            chanOut_ff[i].fallDelta <= act_ff[i].fallDelta;
         end
      end
      assign chanOut[i] = chanOut_ff[i];
   end

   //------------------------------------------------------------------
   // global decoded outputs
   //------------------------------------------------------------------
   wire [4:0] pllField = actGf1_ff[GF1_PLL_LSB +: 5];
   wire       pllOk    = (pllField > PLL_LO) && (pllField < PLL_HI);
   wire       syncOff  = actGf1_ff[GF1_SYNC_OFF];
   wire       pdFull   = actGf1_ff[GF1_PD_FULL];

   // sync clock divider keeps running while the pin is held low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) syncDiv_ff <= 2'h0;
      else syncDiv_ff <= syncDiv_ff + 2'h1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         globOut_ff <= '0;
      end else begin
         globOut_ff.swSync     <= actGf1_ff[GF1_SW_SYNC];
         globOut_ff.hwSync     <= actGf1_ff[GF1_HW_SYNC];
         globOut_ff.testTone   <= actGf1_ff[GF1_TEST_TONE];
         globOut_ff.refPd      <= actGf1_ff[GF1_REF_PD];
         globOut_ff.syncClk    <= ~syncOff & syncDiv_ff[1];
         globOut_ff.syncClkDrv <= ~syncOff;
         globOut_ff.pdDigital  <= pdLvl_ff;
         globOut_ff.pdAll      <= pdLvl_ff & pdFull;
         globOut_ff.clkInPd    <= actGf1_ff[GF1_CLKIN_PD];
         globOut_ff.modLevel   <= actGf1_ff[GF1_MOD_LSB +: 2];
         globOut_ff.cpCurrent  <= actGf1_ff[GF1_CP_LSB +: 2];
         globOut_ff.pllEn      <= pllOk;
         globOut_ff.pllMult    <= pllField;
         globOut_ff.vcoHigh    <= actGf1_ff[GF1_VCO_HIGH];
      end
   end
   assign globOut = globOut_ff;

   //------------------------------------------------------------------
   // read back: globals, else the lowest enabled channel's active copy
   //------------------------------------------------------------------
   logic [1:0]  rdCh;
   logic [31:0] rdMux;
   always_comb begin
      rdCh = 2'h0;
      for (int k = NUM_CHAN - 1; k >= 0; k--) begin
         if (chSel_ff[CHEN_LSB + k]) rdCh = k[1:0];
      end
   end

   always_comb begin
      unique case (rdAddr)
         ADDR_CHSEL: rdMux = {24'h000000, chSel_ff};
         ADDR_GF1:   rdMux = {8'h00, actGf1_ff};
         ADDR_GF2:   rdMux = {16'h0000, actGf2_ff};
         ADDR_CF:    rdMux = {8'h00, act_ff[rdCh].cf};
         ADDR_FTW:   rdMux = act_ff[rdCh].ftw;
         ADDR_POW:   rdMux = {16'h0000, act_ff[rdCh].pow};
         ADDR_AC:    rdMux = {8'h00, act_ff[rdCh].ac};
         ADDR_RATE:  rdMux = {16'h0000, act_ff[rdCh].rate};
         ADDR_RISE:  rdMux = act_ff[rdCh].riseDelta;
         ADDR_FALL:  rdMux = act_ff[rdCh].fallDelta;
         default:    rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) rdData_ff <= 32'h00000000;
      else rdData_ff <= rdMux;
   end
   assign rdData = rdData_ff;

   //------------------------------------------------------------------
   // assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_global_apply_update: assert property (updEvt |=> actGf1_ff == $past(shGf1_ff))
      else $error("global word not applied on update");
   a_global_hold_idle: assert property (!updEvt |=> $stable(actGf1_ff) && $stable(actGf2_ff))
      else $error("global word changed without update");
   a_chan_write_gate: assert property (wrFtw && !chSel_ff[CHEN_LSB] |=> $stable(sh_ff[0].ftw))
      else $error("disabled channel accepted a write");
   a_pll_window: assert property (##1 globOut_ff.pllEn == ($past(pllField) > 5'h03 && $past(pllField) < 5'h15))
      else $error("pll enable outside factor window");
   a_sync_clk_low: assert property (syncOff [*2] |=> !globOut_ff.syncClk && !globOut_ff.syncClkDrv)
      else $error("sync clock not held low");
   a_zero_one_cycle: assert property (chanOut_ff[0].phaseZero |=> !chanOut_ff[0].phaseZero)
      else $error("accumulator zero pulse longer than one cycle");
   a_zero_on_update: assert property (updEvt && shGf2_ff[GF2_PH_AUTO] |=> chanOut_ff[3].phaseZero)
      else $error("global auto clear missed a channel");
   a_sweep_reload: assert property (sweepTmr_ff[0] == 16'h0001 |=> sweepTmr_ff[0] == $past(act_ff[0].rate))
      else $error("sweep timer did not reload at timeout");
   a_no_dwell_gate: assert property (chanOut_ff[1].noDwell |-> $past(act_ff[1].cf[CF_SWEEP]))
      else $error("no-dwell active without sweep");
   a_auto_ramp_gate: assert property (chanOut_ff[2].autoRamp |-> chanOut_ff[2].multEn)
      else $error("auto ramp without multiplier");
   a_full_pd_select: assert property (globOut_ff.pdAll |-> globOut_ff.pdDigital)
      else $error("full power-down without pin level");

   c_update_seen: cover property (updEvt ##1 actGf1_ff != GF1_RESET);
   c_two_chan_write: cover property (wrFtw && chSel_ff[7:4] == 4'h5);
   c_sweep_step: cover property (chanOut_ff[0].sweepStep);
   c_amp_step: cover property (chanOut_ff[0].ampStep);
endmodule : dcr_register_bank

/* File: hw/dcr_pkg.sv */
//----------------------------------------------------------------------
// Contract
// - global bits 0 and 1 enable software and hardware sync; reset 0.
// - global bit 2 enables test-tone modulation; reset 0.
// - global bit 4 powers down the converter reference when set.
// - global bit 5 holds sync clock pin low, driver off; sync logic runs.
// - global bit 6 picks digital-only or full power-down for external pin.
// - global bit 7 puts clock input circuitry into low-power state.
// - global bits 9:8 select 2, 4, 8 or 16 shift-keying levels.
// - global bits 17:16 select charge pump current 75 to 150 uA.
// - PLL enabled with factor bits 22:18 only when value is 4 to 20.
// - global bit 23 selects low or high VCO gain range.
// - second global bits 12/14 hold phase/sweep accumulators cleared.
// - second global bits 13/15 zero all accumulators one cycle per update.
// - channel bit 0 picks cosine (0) or sine (1) conversion.
// - channel bits 1/3 hold that channel's phase/sweep accumulator cleared.
// - channel bits 2/4 zero that channel's accumulators one cycle per update.
// - channel bit 6 powers down converter, bit 7 the digital core.
// - sweep timer reloads on timeout, and on update when channel bit 13.
// - channel bit 14 enables linear sweep; no-dwell bit 15 needs bit 14.
// - amplitude bit 10 adds reload of amplitude timer on update.
// - amplitude bit 12 enables multiplier; clear means bypassed.
// - amplitude bit 11 selects auto ramp only while multiplier enabled.
// - each channel holds 14-bit phase offset and 10-bit scale factor.
// - each channel holds 16-bit ramp rate, 32-bit rising/falling deltas.
// - only channels with enable bits set accept channel register writes.
//----------------------------------------------------------------------
package dcr_pkg;
   localparam int NUM_CHAN = 4;
   // register offsets
   localparam logic [4:0] ADDR_CHSEL = 5'h00;
   localparam logic [4:0] ADDR_GF1   = 5'h01;
   localparam logic [4:0] ADDR_GF2   = 5'h02;
   localparam logic [4:0] ADDR_CF    = 5'h03;
   localparam logic [4:0] ADDR_FTW   = 5'h04;
   localparam logic [4:0] ADDR_POW   = 5'h05;
   localparam logic [4:0] ADDR_AC    = 5'h06;
   localparam logic [4:0] ADDR_RATE  = 5'h07;
   localparam logic [4:0] ADDR_RISE  = 5'h08;
   localparam logic [4:0] ADDR_FALL  = 5'h09;
   // reset values
   localparam logic [7:0]  CHSEL_RESET = 8'hF0;
   localparam logic [23:0] GF1_RESET   = 24'h000000;
   localparam logic [15:0] GF2_RESET   = 16'h0000;
   // field positions
   localparam int CHEN_LSB = 4;
   localparam int GF1_SW_SYNC = 0, GF1_HW_SYNC = 1, GF1_TEST_TONE = 2, GF1_REF_PD = 4;
   localparam int GF1_SYNC_OFF = 5, GF1_PD_FULL = 6, GF1_CLKIN_PD = 7, GF1_MOD_LSB = 8;
   localparam int GF1_CP_LSB = 16, GF1_PLL_LSB = 18, GF1_VCO_HIGH = 23;
   localparam int GF2_PH_HOLD = 12, GF2_PH_AUTO = 13, GF2_SW_HOLD = 14, GF2_SW_AUTO = 15;
   localparam int CF_SINE = 0, CF_PH_HOLD = 1, CF_PH_AUTO = 2, CF_SW_HOLD = 3, CF_SW_AUTO = 4;
   localparam int CF_DAC_PD = 6, CF_DIG_PD = 7, CF_RATE_LD = 13, CF_SWEEP = 14, CF_NO_DWELL = 15;
   localparam int AC_RATE_LD = 10, AC_AUTO = 11, AC_MULT = 12, AC_RATE_LSB = 16;
   // pll factor window (exclusive) and timer timeout value
   localparam logic [4:0]  PLL_LO = 5'h03;
   localparam logic [4:0]  PLL_HI = 5'h15;
   localparam logic [15:0] SWEEP_TIMEOUT = 16'h0001;
   localparam logic [7:0]  AMP_TIMEOUT   = 8'h01;

   typedef struct packed {
      logic [4:0]  addr;
      logic [31:0] data;
   } dcr_wr_t;

   typedef struct packed {
      logic [31:0] fallDelta;
      logic [31:0] riseDelta;
      logic [15:0] rate;
      logic [23:0] ac;
      logic [15:0] pow;
      logic [31:0] ftw;
      logic [23:0] cf;
   } dcr_chan_regs_t;

   typedef struct packed {
      logic       swSync;
      logic       hwSync;
      logic       testTone;
      logic       refPd;
      logic       syncClk;
      logic       syncClkDrv;
      logic       pdDigital;
      logic       pdAll;
      logic       clkInPd;
      logic [1:0] modLevel;
      logic [1:0] cpCurrent;
      logic       pllEn;
      logic [4:0] pllMult;
      logic       vcoHigh;
   } dcr_glob_out_t;

   typedef struct packed {
      logic        sineSel;
      logic        phaseHold;
      logic        sweepHold;
      logic        phaseZero;
      logic        sweepZero;
      logic        dacPd;
      logic        digPd;
      logic        sweepEn;
      logic        noDwell;
      logic        sweepStep;
      logic        ampStep;
      logic        multEn;
      logic        autoRamp;
      logic [9:0]  asf;
      logic [13:0] phaseOfs;
      logic [31:0] ftw;
      logic [15:0] rate;
      logic [31:0] riseDelta;
      logic [31:0] fallDelta;
   } dcr_chan_out_t;
endpackage : dcr_pkg

/* File: verification/dcr_host_model.sv */
`timescale 1ns/1ps
module dcr_host_model (
   // clock
   input  wire logic        clk,
   // write port and update pin towards the bank
   output logic             wrValid,
   output dcr_pkg::dcr_wr_t wr,
   output logic             ioUpdatePin
);
   import dcr_pkg::*;
   //----------------------------------------
   // host side drivers
   //----------------------------------------
   // idle at time zero: no write, update pin low
   initial begin
      wrValid     = 1'b0;
      wr          = '0;
      ioUpdatePin = 1'b0;
   end
   // one write, strobe high across exactly one rising edge
   task automatic write(input logic [4:0] a, input logic [31:0] d);
      @(negedge clk);
      wrValid = 1'b1;
      wr      = '{addr: a, data: d};
      @(negedge clk);
      wrValid = 1'b0;
      wr      = ~wr;   // released bus shows no stale value
   endtask : write
   // update pulse long enough for the filter, then low until applied
   task automatic update();
      @(negedge clk);
      ioUpdatePin = 1'b1;
      repeat (4) @(negedge clk);
      ioUpdatePin = 1'b0;
      repeat (6) @(negedge clk);
   endtask : update
   // pick the target channels before any channel write
   task automatic chan_write(input logic [3:0] en, input logic [4:0] a, input logic [31:0] d);
      write(ADDR_CHSEL, {24'h000000, en, 4'h0});
      write(a, d);
   endtask : chan_write
endmodule : dcr_host_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
   import dcr_pkg::*;
   logic          clk, rst, wrValid, ioUpdatePin, extPowerDownPin;
   dcr_wr_t       wr;
   logic [4:0]    rdAddr;
   logic [31:0]   rdData, v, prev;
   dcr_glob_out_t globOut;
   dcr_chan_out_t chanOut [NUM_CHAN];
   int            error_cnt, n_checks, zeroCnt, zeroSw, swStep, amStep;
   logic [3:0]    sc;
   logic [4:0]    pll [6] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h00, 5'h1F};

   dcr_register_bank dcr_register_bank_inst (.clk(clk), .rst(rst), .wrValid(wrValid), .wr(wr),
      .rdAddr(rdAddr), .rdData(rdData), .ioUpdatePin(ioUpdatePin),
      .extPowerDownPin(extPowerDownPin), .globOut(globOut), .chanOut(chanOut));
   dcr_host_model dcr_host_model_inst (.clk(clk), .wrValid(wrValid), .wr(wr), .ioUpdatePin(ioUpdatePin));

   //----------------------------------------
   // clock, pulse counters, helpers
   //----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count one-cycle pulses away from the rising edge
   always @(negedge clk) begin
      if (chanOut[2].phaseZero === 1'b1) zeroCnt++;
      if (chanOut[1].sweepZero === 1'b1) zeroSw++;
      if (chanOut[0].sweepStep === 1'b1) swStep++;
      if (chanOut[0].ampStep === 1'b1) amStep++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // read two cycles after the address is presented
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(negedge clk);
      rdAddr = a;
      repeat (2) @(negedge clk);
      chk(rdData, e);
   endtask : rd
   // global outputs against a function-one value and pin level
   task automatic gchk(input logic [23:0] g, input logic pin);
      chk(globOut.swSync, g[0]);
      chk(globOut.hwSync, g[1]);
      chk(globOut.testTone, g[2]);
      chk(globOut.refPd, g[4]);
      chk(globOut.syncClkDrv, !g[5]);
      chk(globOut.pdDigital, pin);
      chk(globOut.pdAll, pin & g[6]);
      chk(globOut.clkInPd, g[7]);
      chk(globOut.modLevel, g[9:8]);
      chk(globOut.cpCurrent, g[17:16]);
      chk(globOut.pllMult, g[22:18]);
      chk(globOut.pllEn, g[22:18] > 5'h03 && g[22:18] < 5'h15);
      chk(globOut.vcoHigh, g[23]);
   endtask : gchk
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   // watchdog against a hung run
   initial begin
      #2000000;
      error_cnt++;
      close_out();
   end

   //----------------------------------------
   // test sequence
   //----------------------------------------
   initial begin
      rst = 1'b1; rdAddr = 5'h00; extPowerDownPin = 1'b0; prev = '0;
      error_cnt = 0; n_checks = 0; zeroCnt = 0; zeroSw = 0; swStep = 0; amStep = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      // outputs leave their reset zeros only after the first edges
      repeat (2) @(negedge clk);
      // reset values, read map and an unmapped place
      gchk(24'h000000, 1'b0);
      for (int a = 1; a < 10; a++) rd(a[4:0], 32'h00000000);
      rd(ADDR_CHSEL, {24'h000000, CHSEL_RESET});
      rd(5'h1F, 32'h00000000);
      $display("test reset done");
      // function-one fields, pll window edges, pin modes
      for (int i = 0; i < 6; i++) begin
         v = {8'h00, i[0], pll[i], i[1:0], 6'h00, i[1:0], 8'hFF >> i};
         extPowerDownPin = i[0];
         dcr_host_model_inst.write(ADDR_GF1, v);
         chk(globOut.pllMult, prev[22:18]);
         dcr_host_model_inst.update();
         gchk(v[23:0], i[0]);
         rd(ADDR_GF1, {8'h00, v[23:0]});
         if (v[5]) repeat (8) begin @(negedge clk); chk(globOut.syncClk, 1'b0); end
         else begin
            repeat (4) begin
               @(negedge clk);
               sc = {sc[2:0], globOut.syncClk};
            end
            chk(sc != 4'h0 && sc != 4'hF, 1'b1);
         end
         prev = v;
      end
      $display("test globals done");
      // function-two holds and one auto-zero pulse
      dcr_host_model_inst.write(ADDR_GF2, 32'h0000F000);
      dcr_host_model_inst.update();
      for (int c = 0; c < NUM_CHAN; c++) chk({chanOut[c].phaseHold, chanOut[c].sweepHold}, 2'h3);
      dcr_host_model_inst.write(ADDR_GF2, 32'h00000000);
      dcr_host_model_inst.update();
      chk(chanOut[3].phaseHold, 1'b0);
      chk(zeroCnt, 1);
      chk(zeroSw, 1);
      $display("test function two done");
      // channel steering by enable bits
      dcr_host_model_inst.chan_write(4'h2, ADDR_FTW, 32'h12345678);
      dcr_host_model_inst.chan_write(4'h5, ADDR_FTW, 32'h0BADF00D);
      chk(chanOut[1].ftw, 32'h00000000);
      dcr_host_model_inst.update();
      chk(chanOut[0].ftw, 32'h0BADF00D);
      chk(chanOut[1].ftw, 32'h12345678);
      chk(chanOut[2].ftw, 32'h0BADF00D);
      chk(chanOut[3].ftw, 32'h00000000);
      rd(ADDR_FTW, 32'h0BADF00D);
      $display("test steering done");
      // channel fields, ignored no-dwell and auto ramp
      zeroCnt = 0;
      zeroSw = 0;
      dcr_host_model_inst.chan_write(4'hF, ADDR_CF, 32'h000080DF);
      dcr_host_model_inst.write(ADDR_POW, 32'h0000FFFF);
      dcr_host_model_inst.write(ADDR_AC, 32'h00000BFF);
      dcr_host_model_inst.update();
      chk({chanOut[3].sineSel, chanOut[3].phaseHold}, 2'h3);
      chk(chanOut[0].sweepHold, 1'b1);
      chk({chanOut[1].dacPd, chanOut[1].digPd}, 2'h3);
      chk({chanOut[2].sweepEn, chanOut[2].noDwell}, 2'h0);
      chk({chanOut[0].multEn, chanOut[0].autoRamp}, 2'h0);
      chk(chanOut[3].asf, 10'h3FF);
      chk(chanOut[3].phaseOfs, 14'h3FFF);
      chk(zeroCnt, 1);
      chk(zeroSw, 1);
      $display("test channel fields done");
      // sweep and amplitude timers
      dcr_host_model_inst.write(ADDR_CF, 32'h0000E000);
      dcr_host_model_inst.write(ADDR_RATE, 32'h00000003);
      dcr_host_model_inst.write(ADDR_RISE, 32'hA5A5A5A5);
      dcr_host_model_inst.write(ADDR_FALL, 32'h5A5A5A5A);
      dcr_host_model_inst.write(ADDR_AC, 32'h00041800);
      dcr_host_model_inst.update();
      chk({chanOut[0].sweepEn, chanOut[0].noDwell, chanOut[0].multEn, chanOut[0].autoRamp}, 4'hF);
      chk(chanOut[1].riseDelta, 32'hA5A5A5A5);
      chk(chanOut[2].fallDelta, 32'h5A5A5A5A);
      chk(chanOut[3].rate, 32'h00000003);
      swStep = 0;
      amStep = 0;
      repeat (60) @(negedge clk);
      chk(swStep >= 19 && swStep <= 21, 1'b1);
      chk(amStep >= 14 && amStep <= 16, 1'b1);
      $display("test timers done");
      close_out();
   end
endmodule : tb
